/* rtl/dfll_bod_ctrl.sv */
// Purpose: Loop value/multiplier/read-sync control and brown-out control
// Assumes: Ticks are one-cycle pulses synchronous to sys_clk_in
// Notes:   Brown-out level, action, hysteresis and enable take the user row during reset
// Operation
// [RQ1] Enable reads back written value at once; loop switches after delay
// [RQ2] Closed loop: difference equals ideal minus counted; open loop: frozen
// [RQ3] Coarse field writable open loop, read-only closed loop
// [RQ4] Fine field writable open loop, read-only closed loop
// [RQ5] Coarse change per step limited by coarse maximum step
// [RQ6] Fine change per step limited by fine maximum step
// [RQ7] Multiply factor sets target output cycles per reference period
// [RQ8] Multiply factor write clears locks and centres fine value
// [RQ9] Read request loads fresh values then sets ready flag
// [RQ10] Threshold level selects trigger, loaded from user row
// [RQ11] Software changes threshold only while detector disabled; code writes it on any brown-out register write
// [RQ12] Prescaler divides 1kHz source by two to power code plus one
// [RQ13] Sampling clock enable bit starts and stops sampling clock
// [RQ14] Enable bit reads the settled sampling clock state
// [RQ15] Mode bit picks continuous or prescaled sampled monitoring
// [RQ16] Run-in-standby keeps detector on in standby
// [RQ17] Action picks none, reset or interrupt; loaded from user row
// [RQ18] Hysteresis bit enables hysteresis; loaded from user row
// [RQ19] Enable bit switches detector; loaded from user row
// [RQ20] Mode bit selects open or closed loop
// [RQ21] Unassigned bits read zero and ignore writes
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module dfll_bod_ctrl (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  input  wire logic [7:0]            addr_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [31:0]           rdata_out,
  input  wire logic                  ref_tick_in,
  input  wire logic                  loop_tick_in,
  input  wire logic                  ulp_tick_in,
  input  wire logic                  standby_in,
  input  wire logic                  bod_below_in,
  input  wire dfll_bod_pkg::user_row_s user_row_in,
  output logic                       loop_on_out,
  output logic      [5:0]            coarse_out,
  output logic      [9:0]            fine_out,
  output logic                       bod_enable_out,
  output logic                       bod_sample_out,
  output logic      [5:0]            bod_level_out,
  output logic                       bod_hysteresis_enable_out,
  output logic                       bod_reset_out,
  output logic                       bod_irq_out
);
  // ==================================================
  // Decode
  wire wr_ctrl = wr_in && (addr_in == dfll_bod_pkg::OFS_CTRL);
  wire wr_val  = wr_in && (addr_in == dfll_bod_pkg::OFS_VAL);
  wire wr_mul  = wr_in && (addr_in == dfll_bod_pkg::OFS_MUL);
  wire wr_sync = wr_in && (addr_in == dfll_bod_pkg::OFS_SYNC);
  wire wr_bod  = wr_in && (addr_in == dfll_bod_pkg::OFS_BOD);

  // ==================================================
  // Loop control and value state
  logic                    enable_r;
  logic                    mode_r;
  logic                    loop_on_r;
  logic                    fine_lock_r;
  logic                    prev_neg_r;
  logic                    ready_r;
  logic [15:0]             count_r;
  logic [15:0]             ratio_difference_r;
  logic [5:0]              coarse_r;
  logic [9:0]              fine_r;
  dfll_bod_pkg::mul_reg_s  mul_r;
  dfll_bod_pkg::val_reg_s  snap_r;
  dfll_bod_pkg::loop_st_e  st_r;
  dfll_bod_pkg::loop_st_e  st_nxt;
  logic                    loop_on_sync;
  logic                    rd_done;

  // Switching lags the written bit; readback uses enable_r directly
  sync_delay #(.DEPTH(dfll_bod_pkg::LOOP_SYNC_CYC)) u_en_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       (enable_r),
    .q_out      (loop_on_sync)
  ); // [RQ1]

  wire rd_req = wr_sync && wdata_in[dfll_bod_pkg::SYNC_RDREQ_BIT];
  sync_delay #(.DEPTH(dfll_bod_pkg::READ_SYNC_CYC)) u_rd_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       (rd_req),
    .q_out      (rd_done)
  ); // [RQ9]

  wire closed = mode_r && loop_on_r; // [RQ20]
  wire eval   = closed && ref_tick_in;
  wire [15:0] ratio_difference_now = mul_r.mul - count_r; // [RQ7]
  wire        neg      = ratio_difference_now[15];
  wire [15:0] abs_ratio_difference = neg ? 16'(-ratio_difference_now) : ratio_difference_now;
  wire [5:0]  cmag = (abs_ratio_difference > {10'h0, mul_r.coarse_max_step}) ? mul_r.coarse_max_step
                                                                 : abs_ratio_difference[5:0]; // [RQ5]
  wire [9:0]  fmag = (abs_ratio_difference > {6'h0, mul_r.fine_max_step}) ? mul_r.fine_max_step
                                                             : abs_ratio_difference[9:0]; // [RQ6]
  wire [6:0]  c_up = {1'b0, coarse_r} + {1'b0, cmag};
  wire [6:0]  c_dn = {1'b0, coarse_r} - {1'b0, cmag};
  wire [10:0] f_up = {1'b0, fine_r} + {1'b0, fmag};
  wire [10:0] f_dn = {1'b0, fine_r} - {1'b0, fmag};
  wire [5:0]  coarse_adj = neg ? (c_dn[6] ? 6'h00 : c_dn[5:0])
                               : (c_up[6] ? 6'h3f : c_up[5:0]);
  wire [9:0]  fine_adj   = neg ? (f_dn[10] ? 10'h000 : f_dn[9:0])
                               : (f_up[10] ? 10'h3ff : f_up[9:0]);
  wire coarse_done = (ratio_difference_now == 16'h0) || (neg != prev_neg_r);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      dfll_bod_pkg::ST_OFF: begin
        if (closed) begin
          st_nxt = dfll_bod_pkg::ST_COARSE;
        end
      end
      dfll_bod_pkg::ST_COARSE: begin
        if (!closed) begin
          st_nxt = dfll_bod_pkg::ST_OFF;
        end else if (eval && coarse_done) begin
          st_nxt = dfll_bod_pkg::ST_FINE;
        end
      end
      dfll_bod_pkg::ST_FINE: begin
        if (!closed) begin
          st_nxt = dfll_bod_pkg::ST_OFF;
        end
      end
      default: st_nxt = dfll_bod_pkg::ST_OFF;
    endcase
    if (wr_mul && closed) begin
      st_nxt = dfll_bod_pkg::ST_COARSE; // [RQ8]
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      enable_r  <= 1'b0;
      mode_r    <= 1'b0;
      loop_on_r <= 1'b0;
      st_r      <= dfll_bod_pkg::ST_OFF;
      mul_r     <= '0;
    end else begin
      loop_on_r <= loop_on_sync;
      st_r      <= st_nxt;
      if (wr_ctrl) begin
        enable_r <= wdata_in[dfll_bod_pkg::CTRL_ENABLE_BIT]; // [RQ1]
        mode_r   <= wdata_in[dfll_bod_pkg::CTRL_MODE_BIT];   // [RQ20]
      end
      if (wr_mul) begin
        mul_r <= wdata_in;
      end
    end
  end

  // Output-cycle counter, restarted on every reference tick
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !loop_on_r) begin
      count_r <= 16'h0;
    end else if (ref_tick_in) begin
      count_r <= {15'h0, loop_tick_in};
    end else if (loop_tick_in) begin
      count_r <= count_r + 16'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ratio_difference_r     <= 16'h0;
      prev_neg_r <= 1'b0;
    end else if (eval) begin
      ratio_difference_r     <= ratio_difference_now; // [RQ2]
      prev_neg_r <= neg;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      coarse_r    <= 6'h00;
      fine_r      <= 10'h000;
      fine_lock_r <= 1'b0;
    end else if (wr_mul) begin
      fine_r      <= dfll_bod_pkg::FINE_MID; // [RQ8]
      fine_lock_r <= 1'b0;
    end else if (!mode_r) begin
      fine_lock_r <= 1'b0;
      if (wr_val) begin
        coarse_r <= wdata_in[15:10]; // [RQ3]
        fine_r   <= wdata_in[9:0];   // [RQ4]
      end
    end else if (eval && st_r == dfll_bod_pkg::ST_COARSE) begin
      coarse_r <= coarse_adj; // [RQ5]
    end else if (eval && st_r == dfll_bod_pkg::ST_FINE) begin
      fine_r      <= fine_adj; // [RQ6]
      fine_lock_r <= (ratio_difference_now == 16'h0);
    end
  end

  // Ready set wins over the clear from a new request
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      snap_r  <= '0;
      ready_r <= 1'b0;
    end else if (rd_done) begin
      snap_r  <= '{ratio_difference: ratio_difference_r, coarse: coarse_r, fine: fine_r};
      ready_r <= 1'b1; // [RQ9]
    end else if (rd_req) begin
      ready_r <= 1'b0;
    end
  end

  // ==================================================
  // Brown-out control
  dfll_bod_pkg::bod_reg_s bod_r;
  logic                   samp_clk_run;
  logic [15:0]            presc_r;

  // Threshold, action, hysteresis and enable come from the user row
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bod_r        <= '0;
      bod_r.level  <= user_row_in.level;  // [RQ10]
      bod_r.action <= user_row_in.action; // [RQ17]
      bod_r.hysteresis_enable   <= user_row_in.hysteresis_enable;   // [RQ18]
      bod_r.enable <= user_row_in.enable; // [RQ19]
    end else if (wr_bod) begin
      bod_r.level    <= wdata_in[21:16];
      bod_r.psel     <= wdata_in[15:12];
      bod_r.sampling_clock_enable <= wdata_in[9]; // [RQ13]
      bod_r.mode           <= wdata_in[8];
      bod_r.run_in_standby <= wdata_in[6];
      bod_r.action   <= dfll_bod_pkg::bod_act_e'(wdata_in[4:3]);
      bod_r.hysteresis_enable     <= wdata_in[2];
      bod_r.enable   <= wdata_in[1];
    end
  end

  // Settled clock state: lags both start and stop
  sync_delay #(.DEPTH(dfll_bod_pkg::SAMP_CLK_SYNC_CYC)) u_samp_clk_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       (bod_r.sampling_clock_enable),
    .q_out      (samp_clk_run)
  ); // [RQ14]

  wire [16:0] div_mask  = (17'h2 << bod_r.psel) - 17'h1;
  wire        presc_tick = ulp_tick_in && samp_clk_run
                        && ((presc_r & div_mask[15:0]) == div_mask[15:0]); // [RQ12]
  wire bod_active = bod_r.enable && !(standby_in && !bod_r.run_in_standby); // [RQ16]
  wire sample_now = bod_active && (bod_r.mode ? presc_tick : 1'b1); // [RQ15]
  wire trip       = sample_now && bod_below_in;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !samp_clk_run) begin
      presc_r <= 16'h0; // [RQ13]
    end else if (ulp_tick_in) begin
      presc_r <= presc_r + 16'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bod_enable_out <= 1'b0;
      bod_sample_out <= 1'b0;
      bod_reset_out  <= 1'b0;
      bod_irq_out    <= 1'b0;
    end else begin
      bod_enable_out <= bod_active;
      bod_sample_out <= sample_now;
      bod_reset_out  <= trip && (bod_r.action == dfll_bod_pkg::ACT_RESET); // [RQ17]
      bod_irq_out    <= trip && (bod_r.action == dfll_bod_pkg::ACT_IRQ);
    end
  end

  assign bod_level_out = bod_r.level;
  assign bod_hysteresis_enable_out  = bod_r.hysteresis_enable; // [RQ18]
  assign loop_on_out   = loop_on_r;
  assign coarse_out    = coarse_r;
  assign fine_out      = fine_r;

  // ==================================================
  // Read mux; unassigned bits are zero
  wire [31:0] rd_ctrl = {29'h0, mode_r, enable_r, 1'b0};
  wire [31:0] rd_val  = closed ? snap_r : {snap_r.ratio_difference, coarse_r, fine_r};
  wire [31:0] rd_stat = {28'h0, loop_on_r, fine_lock_r,
                         st_r == dfll_bod_pkg::ST_FINE, ready_r};
  dfll_bod_pkg::bod_reg_s rd_bod_s;
  always_comb begin
    rd_bod_s     = bod_r;
    rd_bod_s.sampling_clock_enable = samp_clk_run; // [RQ14]
  end
  wire [31:0] rd_sel =
      (addr_in == dfll_bod_pkg::OFS_CTRL) ? rd_ctrl :
      (addr_in == dfll_bod_pkg::OFS_VAL)  ? rd_val  :
      (addr_in == dfll_bod_pkg::OFS_MUL)  ? mul_r   :
      (addr_in == dfll_bod_pkg::OFS_BOD)  ? rd_bod_s :
      (addr_in == dfll_bod_pkg::OFS_STAT) ? rd_stat : 32'h0; // [RQ21]

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0;
    end else begin
      rdata_out <= rd_in ? rd_sel : 32'h0;
    end
  end

  // ==================================================
  // Checks
  localparam int RD_MAX = 6;
  localparam int EN_MAX = 5;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_rd_req;
    wr_sync && wdata_in[7];
  endsequence
  sequence s_rd_ready;
    ##[1:RD_MAX] ready_r;
  endsequence

  property p_en_readback;
    wr_ctrl ##1 !wr_ctrl ##1 (rd_in && addr_in == dfll_bod_pkg::OFS_CTRL)
      |=> rdata_out[1] == $past(wdata_in[1], 3);
  endproperty
  a_en_readback: assert property (p_en_readback) else $error("enable readback"); // [RQ1]

  property p_loop_switch;
    $rose(enable_r) ##1 enable_r [*4] |-> loop_on_r;
  endproperty
  a_loop_switch: assert property (p_loop_switch) else $error("loop not on"); // [RQ1]

  property p_ratio_difference;
    eval |=> ratio_difference_r == $past(mul_r.mul) - $past(count_r);
  endproperty
  a_ratio_difference: assert property (p_ratio_difference) else $error("difference wrong"); // [RQ2]

  property p_ratio_difference_hold;
    !mode_r |=> $stable(ratio_difference_r);
  endproperty
  a_ratio_difference_hold: assert property (p_ratio_difference_hold) else $error("ratio_difference changed open"); // [RQ2]

  property p_coarse_ro;
    closed && wr_val && !ref_tick_in |=> $stable(coarse_r);
  endproperty
  a_coarse_ro: assert property (p_coarse_ro) else $error("coarse written"); // [RQ3]

  property p_coarse_step;
    mode_r |=> (coarse_r >= $past(coarse_r) ? coarse_r - $past(coarse_r)
                : $past(coarse_r) - coarse_r) <= mul_r.coarse_max_step;
  endproperty
  a_coarse_step: assert property (p_coarse_step) else $error("coarse step too big"); // [RQ5]

  // A factor write re-centres fine, so that jump is not a step
  property p_fine_step;
    mode_r && !wr_mul |=> (fine_r >= $past(fine_r) ? fine_r - $past(fine_r)
                           : $past(fine_r) - fine_r) <= mul_r.fine_max_step;
  endproperty
  a_fine_step: assert property (p_fine_step) else $error("fine step too big"); // [RQ6]

  property p_mul_write;
    wr_mul |=> fine_r == dfll_bod_pkg::FINE_MID && !fine_lock_r;
  endproperty
  a_mul_write: assert property (p_mul_write) else $error("mul write effect"); // [RQ8]

  property p_read_req;
    s_rd_req |-> s_rd_ready;
  endproperty
  a_read_req: assert property (p_read_req) else $error("ready late"); // [RQ9]

  property p_samp_clk_start;
    wr_bod && wdata_in[9] ##1 bod_r.sampling_clock_enable [*3] |-> ##[0:EN_MAX] samp_clk_run;
  endproperty
  a_samp_clk_start: assert property (p_samp_clk_start) else $error("clock not started"); // [RQ13]

  property p_standby;
    standby_in && !bod_r.run_in_standby |=> !bod_enable_out;
  endproperty
  a_standby: assert property (p_standby) else $error("active in standby"); // [RQ16]
endmodule

/* rtl/dfll_bod_pkg.sv */
// Purpose: Shared offsets, layouts and timing for loop and brown-out control
// Assumes: 32-bit register port, one bus clock
// Notes:   Layout structs place every documented field at its bit position
package dfll_bod_pkg;
  // ==================================================
  // Register offsets
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h24;
  localparam logic [7:0] OFS_VAL  = 8'h28;
  localparam logic [7:0] OFS_MUL  = 8'h2c;
  localparam logic [7:0] OFS_SYNC = 8'h30;
  localparam logic [7:0] OFS_BOD  = 8'h34;

  // ==================================================
  // Bit positions
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_MODE_BIT   = 2;
  localparam int SYNC_RDREQ_BIT  = 7;
  localparam int STAT_READY_BIT  = 0;
  localparam int STAT_CLOCK_BIT  = 1;
  localparam int STAT_FLOCK_BIT  = 2;
  localparam int STAT_RUN_BIT    = 3;

  // ==================================================
  // Fine centre value and cycle counts
  localparam logic [9:0] FINE_MID      = 10'h200;
  localparam int         LOOP_SYNC_CYC = 3;
  localparam int         READ_SYNC_CYC = 4;
  localparam int         SAMP_CLK_SYNC_CYC = 3;

  // ==================================================
  // Layouts
  typedef struct packed {
    logic [15:0] ratio_difference;
    logic [5:0]  coarse;
    logic [9:0]  fine;
  } val_reg_s;

  typedef struct packed {
    logic [5:0]  coarse_max_step;
    logic [9:0]  fine_max_step;
    logic [15:0] mul;
  } mul_reg_s;

  typedef enum logic [1:0] {
    ACT_NONE  = 2'h0,
    ACT_RESET = 2'h1,
    ACT_IRQ   = 2'h2,
    ACT_RSVD  = 2'h3
  } bod_act_e;

  typedef struct packed {
    logic [9:0] rsv_hi;
    logic [5:0] level;
    logic [3:0] psel;
    logic [1:0] rsv_mid;
    logic       sampling_clock_enable;
    logic       mode;
    logic       rsv_7;
    logic       run_in_standby;
    logic       rsv_5;
    bod_act_e   action;
    logic       hysteresis_enable;
    logic       enable;
    logic       rsv_0;
  } bod_reg_s;

  typedef struct packed {
    logic [5:0] level;
    bod_act_e   action;
    logic       hysteresis_enable;
    logic       enable;
  } user_row_s;

  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_COARSE = 2'b01,
    ST_FINE   = 2'b11
  } loop_st_e;
endpackage

/* rtl/sync_delay.sv */
// Purpose: Fixed-depth delay of one bit across a synchroniser-like chain
// Assumes: Synchronous active-high reset
// Notes:   Models the hand-off delay into the loop and sampling domains
`timescale 1ns/1ps
module sync_delay #(
  parameter int DEPTH = 2
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic [DEPTH-1:0] chain_r;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[DEPTH-2:0], d_in};
    end
  end

  assign q_out = chain_r[DEPTH-1];
endmodule

/* test/dfll_bod_ctrl_tb.sv */
// Purpose: Self-checking bench for loop and brown-out register control
// Assumes: One 100 MHz clock, ticks driven as one-cycle pulses
// Notes:   Reset values and register rows first, then loop, read sync and brown-out cases
`timescale 1ns/1ps
module dfll_bod_ctrl_tb;
  // ==================================================
  // Stimulus and observed signals
  logic                    sys_clk;
  logic                    rst;
  logic [7:0]              addr;
  logic [31:0]             wdata;
  logic                    wr_s;
  logic                    rd_s;
  logic [31:0]             rdata;
  logic                    ref_t;
  logic                    loop_t;
  logic                    ulp_t;
  logic                    stby;
  logic                    below;
  dfll_bod_pkg::user_row_s urow;
  logic                    loop_on;
  logic [5:0]              coarse;
  logic [9:0]              fine;
  logic                    bod_en;
  logic                    bod_samp;
  logic [5:0]              bod_lvl;
  logic                    bod_hysteresis_enable;
  logic                    bod_rst;
  logic                    bod_irq;
  int                      miscompares;
  int                      n_checks;
  int                      cyc;
  int                      n_samp;
  int                      n_rst;
  int                      n_irq;
  int                      s0;
  logic [31:0]             d;
  logic [5:0]              c0;

  typedef struct {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] e;
  } row_s;
  // Reserved bits; sampling clock enable kept low since its read-back lags
  row_s rows[5] = '{
    '{8'h2c, 32'hffffffff, 32'hffffffff},
    '{8'h28, 32'hffffffff, 32'h0000ffff},
    '{8'h34, 32'hfffffdfd, 32'h003ff15c},
    '{8'h30, 32'h0000007f, 32'h00000000},
    '{8'h50, 32'hffffffff, 32'h00000000}};

  dfll_bod_ctrl dfll_bod_ctrl_i (
    .sys_clk_in     (sys_clk),
    .rst_in         (rst),
    .addr_in        (addr),
    .wdata_in       (wdata),
    .wr_in          (wr_s),
    .rd_in          (rd_s),
    .rdata_out      (rdata),
    .ref_tick_in    (ref_t),
    .loop_tick_in   (loop_t),
    .ulp_tick_in    (ulp_t),
    .standby_in     (stby),
    .bod_below_in   (below),
    .user_row_in    (urow),
    .loop_on_out    (loop_on),
    .coarse_out     (coarse),
    .fine_out       (fine),
    .bod_enable_out (bod_en),
    .bod_sample_out (bod_samp),
    .bod_level_out  (bod_lvl),
    .bod_hysteresis_enable_out   (bod_hysteresis_enable),
    .bod_reset_out  (bod_rst),
    .bod_irq_out    (bod_irq)
  );

  always #5 sys_clk = ~sys_clk;

  // ==================================================
  // Pulse counters and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (bod_samp === 1'b1) n_samp++;
    if (bod_rst === 1'b1) n_rst++;
    if (bod_irq === 1'b1) n_irq++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ==================================================
  // Tasks
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= w;
    wr_s  <= 1'b1;
    @(posedge sys_clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1 r = rdata;
  endtask

  // Which: 0 reference, 1 loop, 2 sampling source
  task automatic tick(input int which, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      ref_t  <= (which == 0);
      loop_t <= (which == 1);
      ulp_t  <= (which == 2);
      @(posedge sys_clk);
      ref_t  <= 1'b0;
      loop_t <= 1'b0;
      ulp_t  <= 1'b0;
    end
  endtask

  // ==================================================
  // Main sequence
  initial begin
    {sys_clk, wr_s, rd_s, ref_t, loop_t, ulp_t, stby, below} = '0;
    {addr, wdata, cyc, miscompares, n_checks, n_samp, n_rst, n_irq} = '0;
    rst  = 1'b1;
    urow = '{level: 6'h2a, action: dfll_bod_pkg::ACT_IRQ, hysteresis_enable: 1'b1, enable: 1'b0};
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h34, d);
    chk("bod reset", 32'h002a0014, d);
    chk("level out", 32'h2a, {26'h0, bod_lvl});
    chk("hysteresis_enable out", 32'h1, {31'h0, bod_hysteresis_enable});
    rd(8'h28, d);
    chk("val reset", 32'h0, d);
    rd(8'h2c, d);
    chk("mul reset", 32'h0, d);
    for (int i = 0; i < 5; i++) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk("row", rows[i].e, d);
    end
    wr(8'h34, 32'h0);

    // Loop enable reads back at once, switching lags
    wr(8'h24, 32'h2);
    chk("loop on early", 32'h0, {31'h0, loop_on});
    rd(8'h24, d);
    chk("enable readback", 32'h2, d);
    for (int i = 0; i < 20 && loop_on !== 1'b1; i++) @(posedge sys_clk);
    chk("loop on", 32'h1, {31'h0, loop_on});

    // Calibration set open loop, then multiplier write centres fine
    wr(8'h28, 32'h00008100);
    #1 chk("coarse open", 32'h20, {26'h0, coarse});
    chk("fine open", 32'h100, {22'h0, fine});
    wr(8'h2c, 32'h08010005);
    #1 chk("fine mid", {22'h0, dfll_bod_pkg::FINE_MID}, {22'h0, fine});
    wr(8'h24, 32'h6);
    wr(8'h28, 32'h0);
    #1 chk("coarse closed", 32'h20, {26'h0, coarse});
    chk("fine closed", {22'h0, dfll_bod_pkg::FINE_MID}, {22'h0, fine});

    // Two loop cycles against a factor of 5: difference 3, step capped at 2
    tick(0, 1);
    repeat (3) @(posedge sys_clk);
    c0 = coarse;
    tick(1, 2);
    tick(0, 1);
    repeat (3) @(posedge sys_clk);
    d = (coarse > c0) ? 32'(coarse - c0) : 32'(c0 - coarse);
    chk("coarse step", 32'h2, d);
    // Zero difference ends coarse phase; next cycle fine steps by one
    tick(1, 5);
    tick(0, 1);
    tick(1, 2);
    tick(0, 1);
    repeat (3) @(posedge sys_clk);
    chk("fine step", 32'h201, {22'h0, fine});
    wr(8'h30, 32'h80);
    rd(8'h0c, d);
    chk("ready cleared", 32'h0, {31'h0, d[0]});
    for (int i = 0; i < 20 && d[0] !== 1'b1; i++) rd(8'h0c, d);
    chk("ready set", 32'h1, {31'h0, d[0]});
    chk("status", 32'hb, d);
    rd(8'h28, d);
    chk("difference", 32'h3, {16'h0, d[31:16]});
    wr(8'h30, 32'h80);
    rd(8'h0c, d);
    chk("ready recleared", 32'h0, {31'h0, d[0]});

    // Sampling clock enable read-back lags both ways
    wr(8'h34, 32'h00000200);
    rd(8'h34, d);
    chk("samp clk starting", 32'h0, d);
    repeat (6) @(posedge sys_clk);
    rd(8'h34, d);
    chk("samp clk stable", 32'h200, d);
    wr(8'h34, 32'h0);
    rd(8'h34, d);
    chk("samp clk stopping", 32'h200, d);
    repeat (6) @(posedge sys_clk);
    rd(8'h34, d);
    chk("samp clk stopped", 32'h0, d);

    // Sampled mode: pulses per eight source ticks
    for (int p = 0; p < 3; p++) begin
      wr(8'h34, 32'h00000302 | (32'(p) << 12));
      repeat (10) @(posedge sys_clk);
      s0 = n_samp;
      tick(2, 8);
      repeat (4) @(posedge sys_clk);
      chk("samples", 32'(8 >> (p + 1)), 32'(n_samp - s0));
    end

    // Continuous mode, each action code with supply below
    for (int a = 0; a < 4; a++) begin
      wr(8'h34, 32'h00000002 | (32'(a) << 3));
      repeat (4) @(posedge sys_clk);
      chk("continuous", 32'h1, {31'h0, bod_samp});
      chk("bod on", 32'h1, {31'h0, bod_en});
      s0 = n_rst;
      d  = 32'(n_irq);
      below <= 1'b1;
      repeat (6) @(posedge sys_clk);
      below <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("reset act", 32'(a == 1), 32'(n_rst > s0));
      chk("irq act", 32'(a == 2), 32'(n_irq > int'(d)));
    end

    // Standby with and without run-in-standby
    stby <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("standby off", 32'h0, {31'h0, bod_en});
    wr(8'h34, 32'h00000042);
    repeat (4) @(posedge sys_clk);
    chk("standby on", 32'h1, {31'h0, bod_en});
    stby <= 1'b0;
    wr(8'h34, 32'h00000004);
    repeat (3) @(posedge sys_clk);
    chk("bod off", 32'h0, {31'h0, bod_en});
    chk("hysteresis_enable set", 32'h1, {31'h0, bod_hysteresis_enable});
    give_verdict();
  end
endmodule
